// file: logic/mid_decode_top.sv
// Instruction decode, cycle sequencing and read-modify-write control
// for the 8-bit core. Assumes a fetch unit offering words on sys_clk,
// a file space whose read data is valid in the same cycle as the read
// strobe, and an execute unit supplying results and test outcomes.
// Notes on behaviour
// (RULE1) Instructions are one 16-bit word; exactly three take two words.
// (RULE2) Second words start with four ones; alone they act as no_operation.
// (RULE3) Every word decodes into byte, bit, literal or control group.
// (RULE4) Destination bit 0 writes working register; 1 writes file.
// (RULE5) Access bit 0 means access RAM; 1 uses bank select register.
// (RULE6) Bit operations carry a 3-bit number choosing bit 0 to 7.
// (RULE7) Ordinary file address is 8 bits, 0x00 to 0xFF.
// (RULE8) Two-word move gives 12-bit source and destination, no banking.
// (RULE9) Literals are extracted as 8, 12 or 20 bits.
// (RULE10) Table pointer mode: unchanged, post-inc, post-dec or pre-inc.
// (RULE11) Relative branches use two's complement; call/jump absolute.
// (RULE12) Fast bit 1 saves or restores shadow registers; 0 leaves them.
// (RULE13) One cycle; a taken test or PC change adds a no_operation cycle.
// (RULE14) Double-word instructions take two instruction cycles.
// (RULE15) Each instruction cycle spans four oscillator periods.
// (RULE16) A named file register is always read before it is written.
// (RULE17) Call/jump target: bits 7:0 in word one, bits 19:8 in word two.
// (RULE18) Table pointer is 21 bits; transfers use an 8-bit table latch.
// (RULE19) A second word is operand data, never issued on its own; a lone one offered here is still taken and decoded as no_operation.
`timescale 1ns/1ps
module mid_decode_top
  import mid_pkg::*;
(
  input logic sys_clk,
  input logic reset_n,
  input logic [15:0] instr_word,
  input logic instr_valid,
  output logic instr_take,
  input logic [3:0] bank_select_register,
  output logic file_rd_en,
  output logic [11:0] file_addr,
  input logic [7:0] file_rd_data,
  output logic [7:0] operand_data,
  input logic [7:0] exec_result,
  input logic cond_true,
  output logic file_wr_en,
  output logic working_wr_en,
  output logic [7:0] result_data,
  output logic exec_start,
  output logic [1:0] instr_group,
  output logic [3:0] instr_kind,
  output logic [2:0] bit_select,
  output logic [19:0] literal_value,
  output logic pc_load,
  output logic pc_call,
  output logic [19:0] pc_target,
  output logic pc_rel,
  output logic [19:0] pc_offset,
  output logic pc_return,
  output logic shadow_save,
  output logic shadow_restore,
  output logic tbl_en,
  output logic tbl_write,
  output logic [20:0] table_pointer,
  input logic [7:0] tbl_rd_data,
  output logic [7:0] table_latch,
  input logic tptr_load,
  input logic [20:0] tptr_value,
  input logic tlat_load,
  input logic [7:0] tlat_value,
  output logic [1:0] cycle_phase
);

  mid_field_if fld ();

  logic [1:0] phase;
  logic cycle_last;
  mid_state_t state;
  mid_state_t next_state;
  logic live;
  logic next_live;
  mid_kind_t kind;
  mid_kind_t next_kind;
  mid_group_t group;
  mid_group_t next_group;
  logic rd_file;
  logic next_rd_file;
  logic wr_file;
  logic next_wr_file;
  logic wr_work;
  logic next_wr_work;
  logic cond_kind;
  logic next_cond_kind;
  logic alters;
  logic next_alters;
  logic two_word;
  logic next_two_word;
  logic fast;
  logic next_fast;
  mid_ptr_mode_t ptr_mode;
  mid_ptr_mode_t next_ptr_mode;
  logic next_tbl_write;
  logic [2:0] next_bit_select;
  logic [11:0] next_file_addr;
  logic [19:0] next_literal_value;
  logic [19:0] next_pc_target;
  logic [19:0] next_pc_offset;
  logic [7:0] next_operand_data;
  logic [7:0] next_result_data;
  logic [20:0] next_table_pointer;
  logic [7:0] next_table_latch;
  logic [11:0] banked_addr;
  logic cycle1;
  logic cycle2;
  logic ph_read;
  logic ph_mod;
  logic ph_last;
  logic is_move;
  logic is_long;
  logic flush_req;

  mid_phase_seq u_phase (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .phase(phase),
    .cycle_last(cycle_last)
  );

  mid_field_decode u_fields (
    .word(instr_word),
    .fld(fld)
  );

  assign cycle_phase = phase;
  assign instr_group = group;
  assign instr_kind = kind;

  // Phase and cycle qualifiers shared by every strobe below.
  always_comb begin
    ph_read = (phase == PH_READ);
    ph_mod = (phase == PH_MODIFY);
    ph_last = cycle_last;
    cycle1 = live && (state == ST_ISSUE);
    cycle2 = live && (state == ST_SECOND);
    is_move = (kind == K_MOVE);
    is_long = (kind == K_CALL) || (kind == K_JUMP);
  end

  // A word is taken at the first phase whenever one is offered. In the
  // flush cycle the taken word is thrown away, which is how a skipped
  // instruction ends up executed as no_operation.
  assign instr_take = instr_valid && (phase == PH_FIRST); // RULE15

  // Access RAM ignores the bank register and splits into two halves.
  always_comb begin
    if (fld.access_ram) begin
      banked_addr = {(fld.file8 >= ACCESS_SPLIT) ? ACCESS_HI_BANK :
                     ACCESS_LO_BANK, fld.file8}; // RULE5
    end else begin
      banked_addr = {bank_select_register, fld.file8}; // RULE5
    end
  end

  // Strobes towards file space, execute unit and fetch unit.
  always_comb begin
    exec_start = ph_read && cycle1;
    file_rd_en = ph_read && ((cycle1 && rd_file) ||
                             (cycle2 && is_move)); // RULE16
    file_wr_en = ph_last && ((cycle1 && wr_file) ||
                             (cycle2 && is_move)); // RULE4
    working_wr_en = ph_last && cycle1 && wr_work; // RULE4
    tbl_en = ph_mod && cycle1 && (kind == K_TBL); // RULE18
    pc_rel = ph_last && cycle1 && ((kind == K_BRA) ||
             ((kind == K_BCOND) && cond_true)); // RULE11
    pc_return = ph_last && cycle1 && (kind == K_RET);
    pc_load = ph_last && cycle2 && is_long; // RULE14
    pc_call = pc_load && (kind == K_CALL);
    shadow_save = pc_call && fast; // RULE12
    shadow_restore = pc_return && fast; // RULE12
  end

  // A taken test or a program counter change costs one extra cycle;
  // double-word instructions already spend their second cycle instead.
  assign flush_req = cycle1 && !two_word &&
                     (alters || (cond_kind && cond_true)); // RULE13

  // Sequencing state: which kind of cycle runs and whether it is live.
  always_comb begin
    next_state = state;
    next_live = live;
    if (phase == PH_FIRST) begin
      next_live = instr_valid && (state != ST_FLUSH);
    end
    if (ph_last) begin
      case (state)
        ST_ISSUE: begin
          if (live && two_word) begin
            next_state = ST_SECOND; // RULE14
          end else if (flush_req) begin
            next_state = ST_FLUSH; // RULE13
          end else begin
            next_state = ST_ISSUE;
          end
        end
        ST_SECOND: begin
          // Without a second word the cycle repeats until it arrives.
          next_state = live ? ST_ISSUE : ST_SECOND;
        end
        ST_FLUSH: begin
          next_state = ST_ISSUE;
        end
        default: begin
          next_state = ST_ISSUE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= ST_ISSUE;
      live <= 1'b0;
    end else begin
      state <= next_state;
      live <= next_live;
    end
  end

  // Instruction fields and datapath registers.
  always_comb begin
    next_kind = kind;
    next_group = group;
    next_rd_file = rd_file;
    next_wr_file = wr_file;
    next_wr_work = wr_work;
    next_cond_kind = cond_kind;
    next_alters = alters;
    next_two_word = two_word;
    next_fast = fast;
    next_ptr_mode = ptr_mode;
    next_tbl_write = tbl_write;
    next_bit_select = bit_select;
    next_file_addr = file_addr;
    next_literal_value = literal_value;
    next_pc_target = pc_target;
    next_pc_offset = pc_offset;
    next_operand_data = operand_data;
    next_result_data = result_data;
    next_table_pointer = table_pointer;
    next_table_latch = table_latch;
    // Latch a new instruction; a word taken in the flush cycle is dropped.
    if (instr_take && state == ST_ISSUE) begin
      next_kind = fld.kind; // RULE3
      next_group = fld.group; // RULE3
      next_rd_file = fld.reads_file;
      next_wr_file = fld.writes_file;
      next_wr_work = fld.writes_working;
      next_cond_kind = fld.is_cond;
      next_alters = fld.alters_pc;
      next_two_word = fld.two_word; // RULE1
      next_fast = fld.fast;
      next_ptr_mode = fld.ptr_mode; // RULE10
      next_tbl_write = fld.tbl_write;
      next_bit_select = fld.bit_num; // RULE6
      next_file_addr = fld.two_word ? fld.fs12 : banked_addr; // RULE8
      next_literal_value = fld.literal; // RULE9
      next_pc_target = {12'h000, fld.literal[7:0]}; // RULE17
      next_pc_offset = fld.offset; // RULE11
    end
    // The second word only ever supplies operand bits.
    if (instr_take && state == ST_SECOND) begin
      if (is_move) begin
        next_file_addr = instr_word[11:0]; // RULE8
      end else begin
        next_pc_target = {instr_word[11:0], pc_target[7:0]}; // RULE17
        next_literal_value = {instr_word[11:0], pc_target[7:0]}; // RULE9
      end
    end
    // Read phase: capture the file value in cycle one, only for forms that read a file.
    if (ph_read && cycle1 && rd_file) begin
      next_operand_data = file_rd_data; // RULE16
    end
    // Modify phase: the move keeps its source value from cycle one.
    if (ph_mod && cycle1) begin
      next_result_data = exec_result;
    end else if (ph_mod && cycle2 && is_move) begin
      next_result_data = operand_data; // RULE19
    end
    // Table pointer steps around the access; the latch holds the byte.
    if (cycle1 && kind == K_TBL) begin
      if (ph_read && ptr_mode == PM_PRE_INC) begin
        next_table_pointer = table_pointer + 21'h000001; // RULE10
      end
      if (ph_mod && !tbl_write) begin
        next_table_latch = tbl_rd_data; // RULE18
      end
      if (ph_last && ptr_mode == PM_POST_INC) begin
        next_table_pointer = table_pointer + 21'h000001; // RULE10
      end else if (ph_last && ptr_mode == PM_POST_DEC) begin
        next_table_pointer = table_pointer - 21'h000001; // RULE10
      end
    end
    // Direct loads from the file space take priority over stepping.
    if (tptr_load) begin
      next_table_pointer = tptr_value;
    end
    if (tlat_load) begin
      next_table_latch = tlat_value;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      kind <= K_NOP;
      group <= GRP_CTRL;
      rd_file <= 1'b0;
      wr_file <= 1'b0;
      wr_work <= 1'b0;
      cond_kind <= 1'b0;
      alters <= 1'b0;
      two_word <= 1'b0;
      fast <= 1'b0;
      ptr_mode <= PM_KEEP;
      tbl_write <= 1'b0;
      bit_select <= 3'h0;
      file_addr <= 12'h000;
      literal_value <= 20'h00000;
      pc_target <= 20'h00000;
      pc_offset <= 20'h00000;
      operand_data <= 8'h00;
      result_data <= 8'h00;
      table_pointer <= TPTR_RST;
      table_latch <= TLAT_RST;
    end else begin
      kind <= next_kind;
      group <= next_group;
      rd_file <= next_rd_file;
      wr_file <= next_wr_file;
      wr_work <= next_wr_work;
      cond_kind <= next_cond_kind;
      alters <= next_alters;
      two_word <= next_two_word;
      fast <= next_fast;
      ptr_mode <= next_ptr_mode;
      tbl_write <= next_tbl_write;
      bit_select <= next_bit_select;
      file_addr <= next_file_addr;
      literal_value <= next_literal_value;
      pc_target <= next_pc_target;
      pc_offset <= next_pc_offset;
      operand_data <= next_operand_data;
      result_data <= next_result_data;
      table_pointer <= next_table_pointer;
      table_latch <= next_table_latch;
    end
  end

endmodule : mid_decode_top

// file: logic/mid_field_decode.sv
// Combinational split of a first program word into its operand fields.
// Assumes the word is stable while the sequencer samples the fields.
`timescale 1ns/1ps
module mid_field_decode
  import mid_pkg::*;
(
  input wire logic [15:0] word,
  mid_field_if.src fld
);

  logic [3:0] nib;
  assign nib = word[15:12];

  // Group and field extraction; unknown nibbles fall back to no_operation.
  always_comb begin
    fld.group = GRP_CTRL;
    fld.kind = K_NOP;
    fld.dest_file = word[D_POS];
    fld.access_ram = ~word[A_POS]; // RULE5
    fld.bit_num = word[BIT_LSB +: 3]; // RULE6
    fld.file8 = word[7:0]; // RULE7
    fld.fs12 = word[11:0]; // RULE8
    fld.literal = {12'h000, word[7:0]};
    fld.offset = {{9{word[10]}}, word[10:0]};
    fld.ptr_mode = mid_ptr_mode_t'(word[1:0]); // RULE10
    fld.tbl_write = word[TBL_WR_POS];
    fld.fast = word[S_POS];
    fld.is_cond = 1'b0;
    fld.alters_pc = 1'b0;
    fld.two_word = 1'b0;
    fld.reads_file = 1'b0;
    fld.writes_file = 1'b0;
    fld.writes_working = 1'b0;
    if (nib >= OPN_BYTE_LO && nib <= OPN_BYTE_CMP) begin // RULE3
      fld.group = GRP_BYTE;
      fld.kind = K_BYTE;
      fld.reads_file = 1'b1;
      fld.is_cond = (nib == OPN_BYTE_CMP);
      fld.writes_file = (nib != OPN_BYTE_CMP) && word[D_POS]; // RULE4
      fld.writes_working = (nib != OPN_BYTE_CMP) && !word[D_POS]; // RULE4
    end else if (nib >= OPN_BIT_LO && nib <= OPN_BIT_TEST) begin // RULE3
      fld.group = GRP_BIT;
      fld.kind = K_BIT;
      fld.reads_file = 1'b1;
      fld.dest_file = 1'b1;
      fld.is_cond = (nib == OPN_BIT_TEST);
      fld.writes_file = (nib != OPN_BIT_TEST);
    end else if (nib == OPN_LIT12 || nib == OPN_LIT8) begin // RULE3
      fld.group = GRP_LIT;
      fld.kind = (nib == OPN_LIT8) ? K_LIT8 : K_LIT12;
      fld.literal = (nib == OPN_LIT8) ? {12'h000, word[7:0]} :
                    {8'h00, word[11:0]}; // RULE9
      fld.writes_working = (nib == OPN_LIT8);
    end else if (nib == OPN_MOVE) begin
      fld.group = GRP_BYTE;
      fld.kind = K_MOVE;
      fld.reads_file = 1'b1;
      fld.two_word = 1'b1; // RULE1
    end else if (nib == OPN_BRA) begin
      fld.kind = K_BRA;
      fld.alters_pc = 1'b1; // RULE11
    end else if (nib == OPN_LONG) begin
      if (word[SUB_LSB +: 3] == SUB_CALL || word[SUB_LSB +: 3] == SUB_JUMP)
      begin
        fld.kind = (word[SUB_LSB +: 3] == SUB_CALL) ? K_CALL : K_JUMP;
        fld.two_word = 1'b1; // RULE1
        fld.alters_pc = 1'b1;
      end else begin
        fld.kind = K_BCOND;
        fld.is_cond = 1'b1;
        fld.offset = {{12{word[7]}}, word[7:0]}; // RULE11
      end
    end else if (nib == OPN_CTRL) begin
      if (word[7:3] == CTRL_TBL_KEY) begin
        fld.kind = K_TBL;
      end else if (word[7:1] == CTRL_RET_KEY) begin
        fld.kind = K_RET;
        fld.fast = word[0]; // RULE12
        fld.alters_pc = 1'b1;
      end
    end else begin
      // A lone second word, top nibble all ones, is a no_operation.
      fld.kind = K_NOP; // RULE2
    end
  end

endmodule : mid_field_decode

// file: logic/mid_field_if.sv
// Decoded fields of one program word, passed from the field decoder.
// Assumes the decoder drives every signal combinationally.
`timescale 1ns/1ps
interface mid_field_if;
  import mid_pkg::*;
  mid_group_t group;
  mid_kind_t kind;
  logic dest_file;
  logic access_ram;
  logic [2:0] bit_num;
  logic [7:0] file8;
  logic [11:0] fs12;
  logic [19:0] literal;
  logic [19:0] offset;
  mid_ptr_mode_t ptr_mode;
  logic tbl_write;
  logic fast;
  logic is_cond;
  logic alters_pc;
  logic two_word;
  logic reads_file;
  logic writes_file;
  logic writes_working;
  modport src (output group, kind, dest_file, access_ram, bit_num, file8,
    fs12, literal, offset, ptr_mode, tbl_write, fast, is_cond, alters_pc,
    two_word, reads_file, writes_file, writes_working);
  modport sink (input group, kind, dest_file, access_ram, bit_num, file8,
    fs12, literal, offset, ptr_mode, tbl_write, fast, is_cond, alters_pc,
    two_word, reads_file, writes_file, writes_working);
endinterface : mid_field_if

// file: logic/mid_phase_seq.sv
// Four-phase counter that frames each instruction cycle.
// Assumes sys_clk is the oscillator and runs continuously.
`timescale 1ns/1ps
module mid_phase_seq
  import mid_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  output logic [1:0] phase,
  output logic cycle_last
);

  logic [1:0] next_phase;

  // Wrap after the last oscillator period of the cycle.
  always_comb begin
    cycle_last = (phase == PH_LAST);
    next_phase = cycle_last ? PH_FIRST : phase + 2'h1; // RULE15
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      phase <= PH_FIRST;
    end else begin
      phase <= next_phase;
    end
  end

endmodule : mid_phase_seq

// file: logic/mid_pkg.sv
// Shared widths, field positions, opcode map and types for the decoder.
// Assumes a single core clock with one oscillator period per edge.
package mid_pkg;

  // Word, data, address and pointer widths.
  localparam int unsigned WORD_W = 16;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned FADDR_W = 12;
  localparam int unsigned BANK_W = 4;
  localparam int unsigned PC_W = 20;
  localparam int unsigned TPTR_W = 21;

  // Oscillator periods per instruction cycle and phase numbering.
  localparam int unsigned OSC_PER_CYCLE = 4;
  localparam logic [1:0] PH_FIRST = 2'h0;
  localparam logic [1:0] PH_READ = 2'h1;
  localparam logic [1:0] PH_MODIFY = 2'h2;
  localparam logic [1:0] PH_LAST = 2'(OSC_PER_CYCLE - 1);

  // Opcode nibble map, bits 15:12 of the word.
  localparam logic [3:0] OPN_CTRL = 4'h0;
  localparam logic [3:0] OPN_BYTE_LO = 4'h1;
  localparam logic [3:0] OPN_BYTE_CMP = 4'h6;
  localparam logic [3:0] OPN_BIT_LO = 4'h7;
  localparam logic [3:0] OPN_BIT_TEST = 4'h9;
  localparam logic [3:0] OPN_LIT12 = 4'ha;
  localparam logic [3:0] OPN_LIT8 = 4'hb;
  localparam logic [3:0] OPN_MOVE = 4'hc;
  localparam logic [3:0] OPN_BRA = 4'hd;
  localparam logic [3:0] OPN_LONG = 4'he;
  localparam logic [3:0] OPN_SECOND = 4'hf;

  // Field positions inside a word.
  localparam int unsigned D_POS = 9;
  localparam int unsigned A_POS = 8;
  localparam int unsigned S_POS = 8;
  localparam int unsigned BIT_LSB = 9;
  localparam int unsigned SUB_LSB = 9;
  localparam int unsigned TBL_WR_POS = 2;

  // Sub-operation keys.
  localparam logic [2:0] SUB_CALL = 3'h6;
  localparam logic [2:0] SUB_JUMP = 3'h7;
  localparam logic [4:0] CTRL_TBL_KEY = 5'h01;
  localparam logic [6:0] CTRL_RET_KEY = 7'h09;

  // Access region: low half maps to bank 0, high half to the top bank.
  localparam logic [7:0] ACCESS_SPLIT = 8'h80;
  localparam logic [3:0] ACCESS_HI_BANK = 4'hf;
  localparam logic [3:0] ACCESS_LO_BANK = 4'h0;

  // Reset values.
  localparam logic [20:0] TPTR_RST = 21'h000000;
  localparam logic [7:0] TLAT_RST = 8'h00;

  typedef enum logic [1:0] {
    GRP_BYTE = 2'h0, GRP_BIT = 2'h1, GRP_LIT = 2'h2, GRP_CTRL = 2'h3
  } mid_group_t;

  typedef enum logic [3:0] {
    K_NOP = 4'h0, K_BYTE = 4'h1, K_BIT = 4'h2, K_LIT8 = 4'h3,
    K_LIT12 = 4'h4, K_MOVE = 4'h5, K_CALL = 4'h6, K_JUMP = 4'h7,
    K_BRA = 4'h8, K_BCOND = 4'h9, K_RET = 4'ha, K_TBL = 4'hb
  } mid_kind_t;

  typedef enum logic [1:0] {
    PM_KEEP = 2'h0, PM_POST_INC = 2'h1, PM_POST_DEC = 2'h2, PM_PRE_INC = 2'h3
  } mid_ptr_mode_t;

  typedef enum logic [2:0] {
    ST_ISSUE = 3'b001, ST_SECOND = 3'b010, ST_FLUSH = 3'b100
  } mid_state_t;

endpackage : mid_pkg

// file: verif/mid_decode_properties.sv
// Timing checks on the decoder's fetch handshake and execute strobes.
// Assumes it is bound onto the decoder top; one clock, async reset.
`timescale 1ns/1ps
module mid_decode_properties (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic instr_valid,
  input wire logic instr_take,
  input wire logic [1:0] cycle_phase,
  input wire logic file_rd_en,
  input wire logic file_wr_en,
  input wire logic working_wr_en,
  input wire logic tbl_en,
  input wire logic exec_start,
  input wire logic pc_rel,
  input wire logic pc_return,
  input wire logic pc_load,
  input wire logic pc_call,
  input wire logic shadow_save,
  input wire logic shadow_restore
);
  // One clock; every check sleeps through reset.
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  a_take_rule: assert property (
    instr_take == (instr_valid && cycle_phase == 2'h0))
    else $error("fetch take out of phase");
  a_phase_walk: assert property (
    cycle_phase == 2'h0 |=> cycle_phase == 2'h1 ##1 cycle_phase == 2'h2
    ##1 cycle_phase == 2'h3 ##1 cycle_phase == 2'h0)
    else $error("phase sequence broken");
  a_read_first: assert property (
    file_wr_en |-> $past(file_rd_en, 2))
    else $error("file write without earlier read");
  a_read_phase: assert property (
    file_rd_en |-> cycle_phase == 2'h1)
    else $error("file read out of phase");
  a_one_dest: assert property (
    (file_wr_en || working_wr_en) |->
    cycle_phase == 2'h3 && !(file_wr_en && working_wr_en))
    else $error("result destination wrong");
  a_table_phase: assert property (
    tbl_en |-> cycle_phase == 2'h2)
    else $error("table transfer out of phase");
  a_exec_after: assert property (
    exec_start |-> $past(instr_take) && cycle_phase == 2'h1)
    else $error("execute start without take");
  a_flush_quiet: assert property (
    (pc_rel || pc_return) |=> (!file_rd_en && !exec_start)[*4])
    else $error("flush cycle not idle");
  a_save_call: assert property (
    shadow_save |-> pc_call && $past(instr_take, 3))
    else $error("shadow save outside call");
  a_restore_ret: assert property (
    shadow_restore |-> pc_return)
    else $error("shadow restore outside return");
endmodule : mid_decode_properties

// file: verif/mid_decode_top_test.sv
// Directed bench for the decoder top with a file space model.
// Assumes the decoder's four-phase cycle and its two-word pairing.
`timescale 1ns/1ps
module mid_decode_top_test;
  logic sys_clk, reset_n, instr_valid, instr_take, file_rd_en, file_wr_en;
  logic working_wr_en, cond_true, exec_start, pc_load, pc_call, pc_rel;
  logic pc_return, shadow_save, shadow_restore, tbl_en, tbl_write;
  logic tptr_load, tlat_load;
  logic [15:0] instr_word;
  logic [3:0] bank_select_register, instr_kind;
  logic [11:0] file_addr, wr_a, rd_a;
  logic [7:0] file_rd_data, operand_data, exec_result, result_data, wr_d;
  logic [7:0] tbl_rd_data, table_latch, tlat_value;
  logic [1:0] instr_group, cycle_phase;
  logic [2:0] bit_select;
  logic [19:0] literal_value, pc_target, pc_offset;
  logic [20:0] table_pointer, tptr_value, v;
  logic [8:0] ev;
  int miscompares = 0, compares = 0, cycles = 0, n[9], b[9];

  mid_decode_top dut_u (.sys_clk, .reset_n, .instr_word, .instr_valid,
    .instr_take, .bank_select_register, .file_rd_en, .file_addr,
    .file_rd_data, .operand_data, .exec_result, .cond_true, .file_wr_en,
    .working_wr_en, .result_data, .exec_start, .instr_group, .instr_kind,
    .bit_select, .literal_value, .pc_load, .pc_call, .pc_target, .pc_rel,
    .pc_offset, .pc_return, .shadow_save, .shadow_restore, .tbl_en,
    .tbl_write, .table_pointer, .tbl_rd_data, .table_latch, .tptr_load,
    .tptr_value, .tlat_load, .tlat_value, .cycle_phase);
  mid_file_model pm_u (.sys_clk, .file_rd_en, .file_wr_en, .file_addr,
    .result_data, .file_rd_data);

  always #2.5 sys_clk = ~sys_clk;
  assign ev = {pc_return, pc_rel, shadow_restore, shadow_save, pc_call,
    pc_load, file_rd_en, working_wr_en, file_wr_en};

  // Tally strobes at the edge ending their cycle; cut a hang short.
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      summarize();
    end
    for (int i = 0; i < 9; i++) n[i] += (reset_n && ev[i] === 1'b1);
    if (file_wr_en === 1'b1) {wr_a, wr_d} = {file_addr, result_data};
    if (file_rd_en === 1'b1) rd_a = file_addr;
  end

  task summarize;
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : summarize

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Strobe counts since the last mark.
  task evs(input logic [8:0] e, input int rd);
    for (int i = 0; i < 9; i++)
      if (i != 2) chk($sformatf("strobe%0d", i), e[i], n[i] - b[i]);
    chk("reads", rd, n[2] - b[2]);
    b = n;
  endtask : evs

  // Offer a word for the next phase-0 cycle.
  task issue(input logic [15:0] w);
    do @(posedge sys_clk); while (cycle_phase !== 2'h3);
    instr_word <= w;
    instr_valid <= 1'b1;
    @(posedge sys_clk);
    instr_valid <= 1'b0;
  endtask : issue

  task run(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask : run

  task t_bytes;
    issue(16'h1285);
    bank_select_register <= 4'h3;
    run(4);
    evs(9'b000000001, 1);
    chk("wr addr", 12'hf85, wr_a);
    chk("wr data", 8'h5a, wr_d);
    issue(16'h11ff);
    run(4);
    evs(9'b000000010, 1);
    chk("rd addr", 12'h3ff, rd_a);
    issue(16'h7b44);
    run(4);
    chk("group", 2'h1, instr_group);
    chk("bit", 3'h5, bit_select);
    chk("bit addr", 12'h344, rd_a);
    issue(16'hb07f);
    run(4);
    chk("lit8", 20'h0007f, literal_value);
    chk("group", 2'h2, instr_group);
    issue(16'haabc);
    run(4);
    chk("lit12", 20'h00abc, literal_value);
  endtask : t_bytes

  task t_two_word;
    pm_u.mem[12'hfff] = 8'h3c;
    b = n;
    issue(16'hcfff);
    issue(16'hf000);
    run(4);
    evs(9'b000000001, 2);
    chk("move dst", 12'h000, wr_a);
    chk("move data", 8'h3c, wr_d);
    chk("operand", 8'h3c, operand_data);
    issue(16'hed34);
    issue(16'hfabc);
    run(4);
    evs(9'b000111000, 0);
    chk("call tgt", 20'habc34, pc_target);
    issue(16'hee00);
    issue(16'hf001);
    run(4);
    evs(9'b000001000, 0);
    chk("jump tgt", 20'h00100, pc_target);
    issue(16'hf0ff);
    run(4);
    evs(9'b000000000, 0);
  endtask : t_two_word

  // A word offered in a flush cycle must be dropped.
  task t_flow;
    issue(16'hd7ff);
    issue(16'h1285);
    run(4);
    evs(9'b010000000, 0);
    chk("offset", 20'hfffff, pc_offset);
    issue(16'h0013);
    run(4);
    evs(9'b101000000, 0);
    issue(16'h0012);
    run(4);
    evs(9'b100000000, 0);
    issue(16'h6185);
    cond_true <= 1'b1;
    issue(16'h1285);
    cond_true <= 1'b0;
    run(4);
    evs(9'b000000000, 1);
    chk("kind", 4'h1, instr_kind);
  endtask : t_flow

  task t_table;
    for (int m = 0; m < 4; m++) begin
      @(posedge sys_clk);
      tptr_load <= 1'b1;
      @(posedge sys_clk);
      tptr_load <= 1'b0;
      issue(16'h0008 | 16'(m));
      run(4);
      v = (m == 2) ? 21'h0ffffe : (m == 0) ? 21'h0fffff : 21'h100000;
      chk("pointer", v, table_pointer);
      chk("latch", 8'ha5, table_latch);
    end
    @(posedge sys_clk);
    tlat_load <= 1'b1;
    @(posedge sys_clk);
    tlat_load <= 1'b0;
    issue(16'h000c);
    run(4);
    chk("tbl write", 1'b1, tbl_write);
    chk("latch kept", 8'h77, table_latch);
  endtask : t_table

  initial begin
    {sys_clk, reset_n, instr_valid, cond_true, tptr_load, tlat_load} = '0;
    {instr_word, bank_select_register} = '0;
    {tptr_value, tlat_value} = {21'h0fffff, 8'h77};
    exec_result = 8'h5a;
    tbl_rd_data = 8'ha5;
    repeat (8) @(posedge sys_clk);
    reset_n <= 1'b1;
    run(2);
    chk("ptr reset", 21'h0, table_pointer);
    t_bytes();
    t_two_word();
    t_flow();
    t_table();
    summarize();
  end
endmodule : mid_decode_top_test

bind mid_decode_top mid_decode_properties chk_u (.sys_clk, .reset_n,
  .instr_valid, .instr_take, .cycle_phase, .file_rd_en, .file_wr_en,
  .working_wr_en, .tbl_en, .exec_start, .pc_rel, .pc_return, .pc_load,
  .pc_call, .shadow_save, .shadow_restore);

// file: verif/mid_file_model.sv
// File register space model facing the decoder's read and write strobes.
// Assumes read data is wanted in the same cycle as the read strobe.
`timescale 1ns/1ps
module mid_file_model (
  input wire logic sys_clk,
  input wire logic file_rd_en,
  input wire logic file_wr_en,
  input wire logic [11:0] file_addr,
  input wire logic [7:0] result_data,
  output logic [7:0] file_rd_data
);
  logic [7:0] mem [4096];
  logic [7:0] last = 8'h00;

  // Cleared so that a read never returns an unknown.
  initial foreach (mem[i]) mem[i] = 8'h00;

  // Outside a read the bus shows the inverse of its last value.
  assign file_rd_data = file_rd_en ? mem[file_addr] : ~last;

  // Store on the write strobe and remember what the bus carried.
  always @(posedge sys_clk) begin
    if (file_wr_en) mem[file_addr] <= result_data;
    if (file_rd_en) last <= mem[file_addr];
  end
endmodule : mid_file_model
